/* hdl/cosled_status_led.sv */
// Function
// - During node reset both red and green stay dark.
// - Stopped state: green single flash.
// - Pre-operational state: green blinking.
// - Operational state: green steadily on.
// - Error counter at warning level: red single flash.
// - Guarding or heartbeat event: red double flash.
// - Bus off: red steadily on.
// - Slave mode auto bit-rate detection: flicker alternating red and green.
// - Flicker: 50 ms on, 50 ms off, 10 Hz.
// - Blink: 200 ms on, 200 ms off, 2.5 Hz.
// - Single flash: 200 ms on, 1000 ms off, repeating.
// - Double flash: 200 on, 200 off, 200 on, 1000 off, repeating.
// - Steady on is continuously lit, steady off continuously dark.
module cosled_status_led #(
  parameter int unsigned TICK_CYCLES = cosled_pkg::MS_TICK_CYCLES,
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic ledRed,
  output logic ledGreen
);
  import cosled_pkg::*;

  // ==========================================================================
  // Address decode
  // Word decode: the two byte-select bits of the address are ignored
  function automatic logic regHit(input logic [ADDR_W-1:0] addr, input logic [7:0] off);
    logic [7:0] offWord;
    offWord = off >> 2;
    regHit = (addr[ADDR_W-1:2] == (ADDR_W-2)'(offWord));
  endfunction : regHit

  // ==========================================================================
  // Write channel: address and data may arrive in either order
  logic awreadyReg;
  logic awreadyNext;
  logic wreadyReg;
  logic wreadyNext;
  logic awHeldReg;
  logic awHeldNext;
  logic wHeldReg;
  logic wHeldNext;
  logic [ADDR_W-1:0] awAddrReg;
  logic [31:0] wDataReg;
  logic [3:0] wStrbReg;
  logic bvalidReg;
  logic bvalidNext;
  logic [1:0] brespReg;
  logic [1:0] brespNext;

  wire logic awTake = s_axi_awvalid && awreadyReg;
  wire logic wTake = s_axi_wvalid && wreadyReg;
  wire logic awHave = awHeldReg || awTake;
  wire logic wHave = wHeldReg || wTake;
  wire logic doWrite = awHave && wHave;
  wire logic [ADDR_W-1:0] wrAddr = awTake ? s_axi_awaddr : awAddrReg;
  wire logic [31:0] wrData = wTake ? s_axi_wdata : wDataReg;
  wire logic [3:0] wrStrb = wTake ? s_axi_wstrb : wStrbReg;
  wire logic wrCtrl = regHit(wrAddr, CTRL_OFFSET);
  wire logic wrStatus = regHit(wrAddr, STATUS_OFFSET);

  assign awHeldNext = awHave && !doWrite;
  assign wHeldNext = wHave && !doWrite;
  assign bvalidNext = doWrite || (bvalidReg && !s_axi_bready);
  // One write in flight: no new address or data while a response waits
  assign awreadyNext = !awHeldNext && !bvalidNext;
  assign wreadyNext = !wHeldNext && !bvalidNext;
  // Status is read only; a write there is ignored but answered OKAY
  wire logic wrMapped = wrCtrl || wrStatus;
  assign brespNext = doWrite ? (wrMapped ? RESP_OKAY : RESP_SLVERR) : brespReg;

  // Readies fall on their own handshake and come back once the response is taken
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      awreadyReg <= 1'b0;
      wreadyReg <= 1'b0;
    end else begin
      awreadyReg <= awreadyNext;
      wreadyReg <= wreadyNext;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      awHeldReg <= 1'b0;
      wHeldReg <= 1'b0;
    end else begin
      awHeldReg <= awHeldNext;
      wHeldReg <= wHeldNext;
    end
  end

  // ==========================================================================
  // Write response
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      bvalidReg <= 1'b0;
      brespReg <= RESP_OKAY;
    end else begin
      bvalidReg <= bvalidNext;
      brespReg <= brespNext;
    end
  end

  // Payload of whichever half came first, kept until the other half arrives
  always_ff @(posedge clk_sys) begin
    if (awTake) begin
      awAddrReg <= s_axi_awaddr;
    end
    if (wTake) begin
      wDataReg <= s_axi_wdata;
      wStrbReg <= s_axi_wstrb;
    end
  end

  // ==========================================================================
  // Control register: protocol state written by the protocol firmware
  cosled_ctrl_type ctrlReg;
  cosled_ctrl_type ctrlNext;

  // All control bits live in byte lane 0
  assign ctrlNext = (doWrite && wrCtrl && wrStrb[0]) ?
                    cosled_ctrl_type'(wrData[CTRL_W-1:0]) : ctrlReg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ctrlReg <= cosled_ctrl_type'(CTRL_RESET);
    end else begin
      ctrlReg <= ctrlNext;
    end
  end

  // ==========================================================================
  // Condition selection
  cosled_cond_type condReg;
  cosled_cond_type condNext;
  cosled_pat_type patSel;
  logic ledRedReg;
  logic ledRedNext;
  logic ledGreenReg;
  logic ledGreenNext;
  logic patLit;

  wire logic autoBaudOn = ctrlReg.slaveMode && ctrlReg.autoBaud;

  // Reset darkens everything, even a pending bus off; auto baud comes next
  // since no other state is meaningful before the bit rate is known.
  assign condNext = (ctrlReg.nmtState == NMT_RESET) ? COND_RESET :
                    autoBaudOn ? COND_AUTOBAUD :
                    ctrlReg.busOff ? COND_BUSOFF :
                    ctrlReg.errCtrlEvent ? COND_ERRCTL :
                    ctrlReg.warnLimit ? COND_WARN :
                    (ctrlReg.nmtState == NMT_STOPPED) ? COND_STOPPED :
                    (ctrlReg.nmtState == NMT_PREOP) ? COND_PREOP : COND_OPER;

  always_comb begin
    case (condNext)
      COND_RESET: patSel = PAT_OFF;
      COND_AUTOBAUD: patSel = PAT_FLICKER;
      COND_BUSOFF: patSel = PAT_ON;
      COND_ERRCTL: patSel = PAT_DOUBLE;
      COND_WARN: patSel = PAT_SINGLE;
      COND_STOPPED: patSel = PAT_SINGLE;
      COND_PREOP: patSel = PAT_BLINK;
      COND_OPER: patSel = PAT_ON;
      default: patSel = PAT_OFF;
    endcase
  end

  // Any change of the shown condition restarts the pattern at its first lit phase
  wire logic condChange = (condNext != condReg);
  wire logic redCond = (condReg == COND_BUSOFF) || (condReg == COND_ERRCTL) ||
                       (condReg == COND_WARN);
  wire logic greenCond = (condReg == COND_STOPPED) || (condReg == COND_PREOP) ||
                         (condReg == COND_OPER);
  wire logic flickerCond = (condReg == COND_AUTOBAUD);

  // Flicker lights green in the on phase and red in the off phase
  assign ledRedNext = (redCond && patLit) || (flickerCond && !patLit);
  assign ledGreenNext = (greenCond && patLit) || (flickerCond && patLit);

  // ==========================================================================
  // Pattern engine
  cosled_pattern #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_pattern (
    .clk_sys(clk_sys),
    .reset(reset),
    .restart(condChange),
    .pattern(patSel),
    .lit(patLit)
  );

  // ==========================================================================
  // Displayed condition and LED registers
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      condReg <= COND_RESET;
    end else begin
      condReg <= condNext;
    end
  end

  // Both pins switch on the same edge, so no colour overlap at a change
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ledRedReg <= 1'b0;
      ledGreenReg <= 1'b0;
    end else begin
      ledRedReg <= ledRedNext;
      ledGreenReg <= ledGreenNext;
    end
  end

  // ==========================================================================
  // Read channel
  logic arreadyReg;
  logic arreadyNext;
  logic rvalidReg;
  logic rvalidNext;
  logic [31:0] rdataReg;
  logic [1:0] rrespReg;

  wire logic arTake = s_axi_arvalid && arreadyReg;
  wire logic rdCtrl = regHit(s_axi_araddr, CTRL_OFFSET);
  wire logic rdStatus = regHit(s_axi_araddr, STATUS_OFFSET);
  wire logic rdMapped = rdCtrl || rdStatus;

  logic [31:0] statusWord;
  always_comb begin
    statusWord = DATA_ZERO;
    statusWord[$bits(cosled_cond_type)-1:0] = condReg;
    statusWord[STATUS_RED_BIT] = ledRedReg;
    statusWord[STATUS_GREEN_BIT] = ledGreenReg;
  end

  // Unmapped reads return zero with SLVERR so a stray address is easy to spot
  wire logic [31:0] rdWord = rdCtrl ? {{(32 - CTRL_W){1'b0}}, ctrlReg} :
                             (rdStatus ? statusWord : DATA_ZERO);

  // One read in flight: the address channel stays closed while data wait
  assign rvalidNext = arTake || (rvalidReg && !s_axi_rready);
  assign arreadyNext = !rvalidNext;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      arreadyReg <= 1'b0;
      rvalidReg <= 1'b0;
    end else begin
      arreadyReg <= arreadyNext;
      rvalidReg <= rvalidNext;
    end
  end

  // Read data is captured once at the address handshake and held until rready
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rdataReg <= DATA_ZERO;
      rrespReg <= RESP_OKAY;
    end else if (arTake) begin
      rdataReg <= rdWord;
      rrespReg <= rdMapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ==========================================================================
  // Outputs
  assign s_axi_awready = awreadyReg;
  assign s_axi_wready = wreadyReg;
  assign s_axi_bvalid = bvalidReg;
  assign s_axi_bresp = brespReg;
  assign s_axi_arready = arreadyReg;
  assign s_axi_rvalid = rvalidReg;
  assign s_axi_rdata = rdataReg;
  assign s_axi_rresp = rrespReg;
  assign ledRed = ledRedReg;
  assign ledGreen = ledGreenReg;

endmodule : cosled_status_led

/* hdl/cosled_pkg.sv */
package cosled_pkg;

  // ==========================================================================
  // Clock and time base
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MS_IN_NS = 1000000;
  // Cycles per millisecond tick of the pattern timebase
  localparam int unsigned MS_TICK_CYCLES = MS_IN_NS / CLK_PERIOD_NS;

  // ==========================================================================
  // Pattern phase times, in milliseconds
  localparam int unsigned MS_W = 11;
  localparam logic [MS_W-1:0] FLICKER_ON_MS = 11'h032;   // 50 ms
  localparam logic [MS_W-1:0] FLICKER_OFF_MS = 11'h032;  // 50 ms
  localparam logic [MS_W-1:0] BLINK_ON_MS = 11'h0C8;     // 200 ms
  localparam logic [MS_W-1:0] BLINK_OFF_MS = 11'h0C8;    // 200 ms
  localparam logic [MS_W-1:0] FLASH_ON_MS = 11'h0C8;     // 200 ms
  localparam logic [MS_W-1:0] FLASH_GAP_MS = 11'h0C8;    // 200 ms
  localparam logic [MS_W-1:0] FLASH_LONG_OFF_MS = 11'h3E8; // 1,000 ms
  localparam logic [MS_W-1:0] MS_ZERO = 11'h000;
  localparam logic [MS_W-1:0] MS_ONE = 11'h001;

  // ==========================================================================
  // Display patterns and shown conditions
  typedef enum logic [2:0] {
    PAT_OFF = 3'h0,
    PAT_ON = 3'h1,
    PAT_FLICKER = 3'h2,
    PAT_BLINK = 3'h3,
    PAT_SINGLE = 3'h4,
    PAT_DOUBLE = 3'h5
  } cosled_pat_type;

  typedef enum logic [2:0] {
    COND_RESET = 3'h0,
    COND_AUTOBAUD = 3'h1,
    COND_BUSOFF = 3'h2,
    COND_ERRCTL = 3'h3,
    COND_WARN = 3'h4,
    COND_STOPPED = 3'h5,
    COND_PREOP = 3'h6,
    COND_OPER = 3'h7
  } cosled_cond_type;

  typedef enum logic [1:0] {
    NMT_RESET = 2'h0,
    NMT_STOPPED = 2'h1,
    NMT_PREOP = 2'h2,
    NMT_OPER = 2'h3
  } cosled_nmt_type;

  // ==========================================================================
  // Register map
  typedef struct packed {
    logic autoBaud;
    logic busOff;
    logic errCtrlEvent;
    logic warnLimit;
    cosled_nmt_type nmtState;
    logic slaveMode;
  } cosled_ctrl_type;

  localparam int unsigned CTRL_W = 7;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] STATUS_OFFSET = 8'h04;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 7'h00;
  localparam int unsigned STATUS_RED_BIT = 4;
  localparam int unsigned STATUS_GREEN_BIT = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage : cosled_pkg

/* hdl/cosled_pattern.sv */
module cosled_pattern #(
  parameter int unsigned TICK_CYCLES = cosled_pkg::MS_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic restart,
  input wire cosled_pkg::cosled_pat_type pattern,
  output logic lit
);
  import cosled_pkg::*;

  localparam int unsigned DIV_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
  localparam logic [DIV_W-1:0] DIV_ZERO = '0;

  // ==========================================================================
  // Phase decoding
  function automatic logic [MS_W-1:0] periodOf(input cosled_pat_type p);
    case (p)
      PAT_BLINK: periodOf = BLINK_ON_MS + BLINK_OFF_MS;
      PAT_SINGLE: periodOf = FLASH_ON_MS + FLASH_LONG_OFF_MS;
      PAT_DOUBLE: periodOf = FLASH_ON_MS + FLASH_GAP_MS + FLASH_ON_MS + FLASH_LONG_OFF_MS;
      default: periodOf = FLICKER_ON_MS + FLICKER_OFF_MS;
    endcase
  endfunction : periodOf

  function automatic logic phaseLit(input cosled_pat_type p, input logic [MS_W-1:0] ms);
    case (p)
      PAT_ON: phaseLit = 1'b1;
      PAT_FLICKER: phaseLit = (ms < FLICKER_ON_MS);
      PAT_BLINK: phaseLit = (ms < BLINK_ON_MS);
      PAT_SINGLE: phaseLit = (ms < FLASH_ON_MS);
      PAT_DOUBLE: phaseLit = (ms < FLASH_ON_MS) ||
        ((ms >= FLASH_ON_MS + FLASH_GAP_MS) &&
         (ms < FLASH_ON_MS + FLASH_GAP_MS + FLASH_ON_MS));
      default: phaseLit = 1'b0;
    endcase
  endfunction : phaseLit

  // ==========================================================================
  // Millisecond timebase and position within the period
  logic [DIV_W-1:0] divReg;
  logic [DIV_W-1:0] divNext;
  logic [MS_W-1:0] msReg;
  logic [MS_W-1:0] msNext;
  logic litReg;
  logic litNext;
  wire logic tickDone = (divReg == DIV_LAST);
  wire logic periodEnd = (msReg == periodOf(pattern) - MS_ONE);

  // Restart clears the divider too, so the first lit phase is full length
  assign divNext = (restart || tickDone) ? DIV_ZERO : divReg + DIV_W'(1);
  assign msNext = restart ? MS_ZERO :
                  (tickDone ? (periodEnd ? MS_ZERO : msReg + MS_ONE) : msReg);
  assign litNext = phaseLit(pattern, msNext);
  assign lit = litReg;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      divReg <= DIV_ZERO;
      msReg <= MS_ZERO;
      litReg <= 1'b0;
    end else begin
      divReg <= divNext;
      msReg <= msNext;
      litReg <= litNext;
    end
  end

endmodule : cosled_pattern

/* bench/cosled_chk.sv */
module cosled_chk
  import cosled_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = 4,
  parameter int unsigned ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ledRed,
  input wire logic ledGreen
);
  // ==========
  // Lit run lengths; a CTRL write shows its new pattern two edges later
  localparam int FLK = 50 * TICK_CYCLES;
  localparam int PH = 200 * TICK_CYCLES;
  wire logic ctrlWr = s_axi_awvalid && s_axi_awready && s_axi_awaddr[ADDR_W-1:2] == '0;
  wire logic arHs = s_axi_arvalid && s_axi_arready;
  wire logic [ADDR_W-3:0] arIdx = s_axi_araddr[ADDR_W-1:2];
  int redRun;
  int greenRun;
  int sinceWr;
  wire logic restart = (sinceWr == 1);
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      redRun <= 0;
      greenRun <= 0;
      sinceWr <= 15;
    end else begin
      redRun <= (ledRed && !restart) ? redRun + 1 : 0;
      greenRun <= (ledGreen && !restart) ? greenRun + 1 : 0;
      sinceWr <= ctrlWr ? 0 : (sinceWr < 15 ? sinceWr + 1 : 15);
    end
  end

  // ==========
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  a_reset_dark: assert property (disable iff (1'b0) reset |=> !ledRed && !ledGreen)
    else $error("led lit after reset edge");
  a_release_dark: assert property ($fell(reset) |-> (!ledRed && !ledGreen) [*3])
    else $error("led lit right after reset release");
  a_one_colour: assert property (!(ledRed && ledGreen))
    else $error("red and green lit together");
  a_green_phase: assert property ($fell(ledGreen) |->
    greenRun inside {FLK, PH} || sinceWr == 2)
    else $error("green lit phase of wrong length");
  a_red_phase: assert property ($fell(ledRed) |->
    redRun inside {FLK, PH} || sinceWr == 2)
    else $error("red lit phase of wrong length");
  a_read_answer: assert property (arHs |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before rready");
  a_write_answer: assert property (ctrlWr && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write response late");
  a_unmapped_read: assert property (arHs && arIdx > 1 |=>
    s_axi_rresp == RESP_SLVERR && s_axi_rdata == DATA_ZERO)
    else $error("unmapped read not refused");
  a_ctrl_upper: assert property (arHs && arIdx == 0 |=>
    s_axi_rresp == RESP_OKAY && s_axi_rdata[31:7] == '0)
    else $error("control upper bits not zero");
  c_flicker: cover property (ledGreen ##1 ledRed);
  c_red_flash: cover property ($fell(ledRed) && redRun == PH && sinceWr == 15);
  c_unmapped: cover property (arHs && arIdx > 1);
endmodule : cosled_chk

bind cosled_status_led cosled_chk #(.TICK_CYCLES(TICK_CYCLES), .ADDR_W(ADDR_W)) u_chk (
  .clk_sys, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ledRed, .ledGreen);

/* bench/cosled_led_model.sv */
module cosled_led_model (
  input wire logic ledRed,
  input wire logic ledGreen,
  output logic [1:0] shown
);
  // ==========
  // Duo element: both dies lit would look amber, so keep both bits
  assign shown = {ledRed, ledGreen};
endmodule : cosled_led_model

/* bench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cosled_pkg::*;
  // ==========
  // Signals
  localparam int T = 4;
  localparam int FL = 50 * T;
  localparam int PH = 200 * T;
  localparam int LG = 1000 * T;
  localparam logic [1:0] D = 2'b00, G = 2'b01, R = 2'b10;
  logic clk_sys, reset;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [31:0] s_axi_wdata, s_axi_rdata, v;
  logic [3:0] s_axi_wstrb, s;
  logic [1:0] s_axi_bresp, s_axi_rresp, shown;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ledRed, ledGreen;
  logic [33:0] rdQ[$];
  logic [1:0] wrQ[$];
  logic [6:0] shadow;
  int n_mismatch = 0;
  int checked = 0;
  int cycles = 0;

  cosled_status_led #(.TICK_CYCLES(T)) u_dut (.clk_sys, .reset, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .ledRed,
    .ledGreen);
  cosled_led_model u_led (.ledRed, .ledGreen, .shown);

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ==========
  // Tasks
  task fail(input string msg);
    n_mismatch++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail

  task stop_test;
    $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                          input logic [1:0] r);
    logic awDone = 1'b0;
    logic wDone = 1'b0;
    @(posedge clk_sys);
    wrQ.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= st;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      awDone |= s_axi_awready;
      wDone |= s_axi_wready;
      if (awDone) s_axi_awvalid <= 1'b0;
      if (wDone) s_axi_wvalid <= 1'b0;
    end while (!(awDone && wDone));
    do @(posedge clk_sys); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : axiWrite

  // The late rready lets the read data be seen waiting
  task automatic axiRead(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge clk_sys);
    rdQ.push_back({r, d});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    @(posedge clk_sys);
    s_axi_rready <= 1'b1;
    do @(posedge clk_sys); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask : axiRead

  task automatic seg(input logic [1:0] c, input int len);
    checked++;
    if (shown !== c) fail("wrong colour at phase start");
    repeat (len - 1) @(posedge clk_sys);
    #1;
    checked++;
    if (shown !== c) fail("wrong colour at phase end");
    @(posedge clk_sys);
    #1;
  endtask : seg

  task automatic pat(input logic [6:0] c, input logic [1:0] col[4], input int len[4]);
    axiWrite(CTRL_OFFSET, {25'h0, c}, 4'hF, RESP_OKAY);
    // The task returns one edge after the write edge; the pins change one edge later
    @(posedge clk_sys);
    #1;
    foreach (col[i]) seg(col[i], len[i]);
  endtask : pat

  // ==========
  // Response monitor and watchdog
  always @(posedge clk_sys) begin
    if (s_axi_rvalid && s_axi_rready) begin
      checked++;
      if ({s_axi_rresp, s_axi_rdata} !== rdQ.pop_front()) fail("read response");
    end
    if (s_axi_bvalid && s_axi_bready) begin
      checked++;
      if (s_axi_bresp !== wrQ.pop_front()) fail("write response");
    end
    cycles++;
    if (cycles == 60000) begin
      fail("timeout");
      stop_test();
    end
  end

  // ==========
  // Scenarios
  initial begin
    reset = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    void'($urandom(56320));
    repeat (4) @(posedge clk_sys);
    reset <= 1'b0;
    checked++;
    if (shown !== D) fail("lit during reset");
    axiRead(CTRL_OFFSET, DATA_ZERO, RESP_OKAY);
    axiRead(STATUS_OFFSET, DATA_ZERO, RESP_OKAY);
    pat(7'h02, '{G, D, G, D}, '{PH, LG, PH, PH});
    pat(7'h04, '{G, D, G, D}, '{PH, PH, PH, PH});
    pat(7'h0E, '{R, D, R, D}, '{PH, LG, PH, PH});
    pat(7'h1E, '{R, D, R, D}, '{PH, PH, PH, LG});
    pat(7'h3E, '{R, R, R, R}, '{PH, PH, PH, PH});
    axiRead(STATUS_OFFSET, 32'h0000_0012, RESP_OKAY);
    pat(7'h7F, '{G, R, G, R}, '{FL, FL, FL, FL});
    pat(7'h7E, '{R, R, R, R}, '{FL, FL, FL, FL});
    pat(7'h06, '{G, G, G, G}, '{PH, PH, PH, PH});
    axiRead(STATUS_OFFSET, 32'h0000_0027, RESP_OKAY);
    axiWrite(STATUS_OFFSET, 32'hFFFF_FFFF, 4'hF, RESP_OKAY);
    axiWrite(CTRL_OFFSET, DATA_ZERO, 4'hE, RESP_OKAY);
    axiWrite(8'h08, DATA_ZERO, 4'hF, RESP_SLVERR);
    axiRead(8'h0C, DATA_ZERO, RESP_SLVERR);
    axiRead(CTRL_OFFSET, 32'h0000_0006, RESP_OKAY);
    checked++;
    if (shown !== G) fail("steady green disturbed");
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    checked++;
    if (shown !== D) fail("lit during reset");
    @(posedge clk_sys);
    reset <= 1'b0;
    axiRead(CTRL_OFFSET, DATA_ZERO, RESP_OKAY);
    pat(7'h38, '{D, D, D, D}, '{PH, PH, PH, PH});
    shadow = 7'h38;
    repeat (6) begin
      v = $urandom;
      s = 4'($urandom);
      v[2:1] = 2'b00;
      if (s[0]) shadow = v[6:0];
      axiWrite(CTRL_OFFSET, v, s, RESP_OKAY);
      axiRead(CTRL_OFFSET, {25'h0, shadow}, RESP_OKAY);
      checked++;
      if (shown !== D) fail("lit while node in reset");
    end
    stop_test();
  end
endmodule : tb_top
